// file: pkg/cso_pkg.sv
// shared constants and types for the sync and ordering control block
package cso_pkg;
	// decoded instruction classes presented at issue
	typedef enum logic [3:0] {
		CSO_OP_PLAIN = 4'h0,
		CSO_OP_ISYNC = 4'h1,
		CSO_OP_RFI = 4'h2,
		CSO_OP_RFCI = 4'h3,
		CSO_OP_SYSCALL = 4'h4,
		CSO_OP_SYNC = 4'h5,
		CSO_OP_IOBAR = 4'h6,
		CSO_OP_MTMSR = 4'h7,
		CSO_OP_WREE = 4'h8,
		CSO_OP_MTDCR = 4'h9,
		CSO_OP_MFDCR = 4'ha,
		CSO_OP_ICINV = 4'hb
	} cso_op_type;

	typedef enum logic [3:0] {
		CSO_ST_RUN = 4'h1,
		CSO_ST_DRAIN = 4'h2,
		CSO_ST_MEMWAIT = 4'h4,
		CSO_ST_REFETCH = 4'h8
	} cso_state_type;

	localparam logic CSO_EE_RESET = 1'b0;
	localparam logic CSO_USER_RESET = 1'b0;
endpackage : cso_pkg

// file: hdl/cso_classify.sv
// instruction class decode for sync and ordering behaviour
`timescale 1ns/1ps
`default_nettype none
module cso_classify
	import cso_pkg::*;
(
	// decoded op
	input wire cso_op_type op,
	input wire logic user_mode,
	// classes
	output logic ctx_sync,
	output logic exec_sync,
	output logic mem_barrier,
	output logic priv_fault
);
	always_comb begin
		ctx_sync = (op == CSO_OP_ISYNC) || (op == CSO_OP_RFI) || (op == CSO_OP_RFCI) ||
			(op == CSO_OP_SYSCALL);
		// both barriers share the full-sync behaviour
		mem_barrier = (op == CSO_OP_SYNC) || (op == CSO_OP_IOBAR);
		// external-enable writes are not execution synchronizing
		exec_sync = mem_barrier || (op == CSO_OP_MTMSR);
		priv_fault = user_mode && ((op == CSO_OP_MTDCR) || (op == CSO_OP_MFDCR) ||
			(op == CSO_OP_RFI) || (op == CSO_OP_RFCI) || (op == CSO_OP_MTMSR) ||
			(op == CSO_OP_WREE));
	end
endmodule // cso_classify
`default_nettype wire

// file: hdl/cso_msr.sv
// privilege and external-enable state, both cleared on interrupt entry
`timescale 1ns/1ps
`default_nettype none
module cso_msr
	import cso_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// updates
	input wire logic wr_en,
	input wire logic wr_user,
	input wire logic wr_ee,
	input wire logic ee_only_en,
	input wire logic ee_only_val,
	input wire logic intr_enter,
	// state
	output logic user_mode,
	output logic ee
);
	logic user_r, user_nxt, ee_r, ee_nxt;
	always_comb begin
		user_nxt = user_r;
		ee_nxt = ee_r;
		if (intr_enter) begin
			// interrupts enter privileged mode with external enable off
			user_nxt = 1'b0;
			ee_nxt = 1'b0;
		end else if (wr_en) begin
			user_nxt = wr_user;
			ee_nxt = wr_ee;
		end else if (ee_only_en) begin
			ee_nxt = ee_only_val;
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			user_r <= CSO_USER_RESET;
			ee_r <= CSO_EE_RESET;
		end else begin
			user_r <= user_nxt;
			ee_r <= ee_nxt;
		end
	end
	assign user_mode = user_r;
	assign ee = ee_r;
endmodule // cso_msr
`default_nettype wire

// file: hdl/cso_ctrl.sv
// synchronization and ordering control between fetch, execute and load/store
`timescale 1ns/1ps
`default_nettype none
module cso_ctrl
	import cso_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// issue stage
	input wire logic issue_valid,
	input wire cso_op_type issue_op,
	input wire logic [1:0] issue_msr_val,
	output logic issue_ready,
	output logic issue_fire,
	// execute pipeline
	input wire logic pipe_empty,
	// load/store unit
	input wire logic lsu_idle,
	output logic lsu_hold,
	// interrupts
	input wire logic ext_irq_pending,
	input wire logic irq_event,
	input wire logic irq_nonrecov_imc,
	output logic take_ext_irq,
	output logic priv_exc,
	// fetch and prefetch queue
	output logic pfq_flush,
	output logic refetch_req,
	output logic fetch_hold,
	// status
	output logic user_mode,
	output logic ext_int_enable,
	output logic ctx_switch
);
	logic ctx_sync, exec_sync, mem_barrier, priv_fault;
	logic ee, msr_wr, ee_wr, intr_enter;
	cso_state_type state_r, state_nxt;
	logic pend_ctx_r, pend_ctx_nxt;
	logic ee_chk_r, ee_chk_nxt;
	logic flush_r, flush_nxt;
	logic exc_r, exc_nxt;
	logic take_r, take_nxt;
	logic ctx_r, ctx_nxt;

	cso_classify cso_classify_inst (
		.op(issue_op),
		.user_mode(user_mode),
		.ctx_sync(ctx_sync),
		.exec_sync(exec_sync),
		.mem_barrier(mem_barrier),
		.priv_fault(priv_fault)
	);

	// state write lands as the op issues; only the full state write waits for the pipe to drain
	assign msr_wr = issue_fire && (issue_op == CSO_OP_MTMSR) && !priv_fault;
	assign ee_wr = issue_fire && (issue_op == CSO_OP_WREE) && !priv_fault;
	// recoverable interrupts and privileged faults sync context
	assign intr_enter = (irq_event && !irq_nonrecov_imc) || take_r || exc_r;

	cso_msr cso_msr_inst (
		.clk(clk),
		.arst_n(arst_n),
		.wr_en(msr_wr),
		.wr_user(issue_msr_val[1]),
		.wr_ee(issue_msr_val[0]),
		.ee_only_en(ee_wr),
		.ee_only_val(issue_msr_val[0]),
		.intr_enter(intr_enter),
		.user_mode(user_mode),
		.ee(ee)
	);

	always_comb begin
		state_nxt = state_r;
		pend_ctx_nxt = pend_ctx_r;
		ee_chk_nxt = 1'b0;
		flush_nxt = 1'b0;
		exc_nxt = 1'b0;
		take_nxt = 1'b0;
		ctx_nxt = 1'b0;
		issue_ready = 1'b0;
		case (state_r)
			CSO_ST_RUN: begin
				// exec/context sync ops wait for older work before issuing
				issue_ready = !ee_chk_r && !((exec_sync || ctx_sync) && !pipe_empty);
				// full sync also waits for every older storage access
				if (issue_valid && mem_barrier && pipe_empty && !lsu_idle) begin
					issue_ready = 1'b0;
					state_nxt = CSO_ST_MEMWAIT;
				end
				if (issue_valid && issue_ready) begin
					if (priv_fault) begin
						exc_nxt = 1'b1;
						flush_nxt = 1'b1;
						// younger op must not issue while the fault flushes
						state_nxt = CSO_ST_REFETCH;
					end else if (ctx_sync) begin
						// discard younger prefetch; memory not ordered here
						flush_nxt = 1'b1;
						ctx_nxt = 1'b1;
						state_nxt = CSO_ST_REFETCH;
					end else if (issue_op == CSO_OP_MTMSR) begin
						// prefetched instructions stay valid after a state write
						ee_chk_nxt = 1'b1;
					end
				end
				if (ee_chk_r && ee && ext_irq_pending) begin
					take_nxt = 1'b1;
					flush_nxt = 1'b1;
					state_nxt = CSO_ST_REFETCH;
				end
			end
			CSO_ST_MEMWAIT: begin
				// own accesses only; nothing crosses to other processors
				if (lsu_idle) begin
					state_nxt = CSO_ST_RUN;
				end
			end
			CSO_ST_REFETCH: begin
				state_nxt = CSO_ST_RUN;
			end
			CSO_ST_DRAIN: begin
				state_nxt = CSO_ST_RUN;
			end
			default: begin
				state_nxt = CSO_ST_RUN;
			end
		endcase
		// recoverable interrupts are honoured in every state, also aborting a barrier wait
		if (irq_event && !irq_nonrecov_imc) begin
			flush_nxt = 1'b1;
			ctx_nxt = 1'b1;
			state_nxt = CSO_ST_REFETCH;
		end
		if (exc_r || take_r) begin
			ctx_nxt = 1'b1;
		end
		pend_ctx_nxt = flush_nxt;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= CSO_ST_RUN;
			pend_ctx_r <= 1'b0;
			ee_chk_r <= 1'b0;
			flush_r <= 1'b0;
			exc_r <= 1'b0;
			take_r <= 1'b0;
			ctx_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pend_ctx_r <= pend_ctx_nxt;
			ee_chk_r <= ee_chk_nxt;
			flush_r <= flush_nxt;
			exc_r <= exc_nxt;
			take_r <= take_nxt;
			ctx_r <= ctx_nxt;
		end
	end

	assign issue_fire = issue_valid && issue_ready;
	// barriers never gate fetch or purge the queue
	assign fetch_hold = 1'b0;
	// hold later storage accesses while a barrier waits; control-register moves ride it too
	assign lsu_hold = (state_r == CSO_ST_MEMWAIT);
	assign pfq_flush = flush_r;
	assign refetch_req = pend_ctx_r;
	assign priv_exc = exc_r;
	assign take_ext_irq = take_r;
	assign ctx_switch = ctx_r;
	assign ext_int_enable = ee;

	a_priv_dcr_fault: assert property (@(posedge clk) disable iff (!arst_n)
		(issue_fire && user_mode && (issue_op == CSO_OP_MTDCR || issue_op == CSO_OP_MFDCR))
		|=> priv_exc && pfq_flush)
		else $error("user-mode control move did not fault");
	a_ctx_flush_seen: assert property (@(posedge clk) disable iff (!arst_n)
		(issue_fire && issue_op == CSO_OP_ISYNC && !user_mode) |=> pfq_flush ##0 refetch_req)
		else $error("isync did not flush and refetch");
	a_sync_waits_lsu: assert property (@(posedge clk) disable iff (!arst_n)
		(issue_fire && (issue_op == CSO_OP_SYNC || issue_op == CSO_OP_IOBAR)) |-> lsu_idle)
		else $error("barrier issued with storage outstanding");
	a_exec_drained: assert property (@(posedge clk) disable iff (!arst_n)
		(issue_fire && (issue_op == CSO_OP_MTMSR || issue_op == CSO_OP_SYNC)) |-> pipe_empty)
		else $error("execution sync issued before older work drained");
	a_memwait_hold: assert property (@(posedge clk) disable iff (!arst_n)
		(state_r == CSO_ST_MEMWAIT) |-> lsu_hold && !issue_ready)
		else $error("later access allowed past barrier");
	a_no_fetch_stall: assert property (@(posedge clk) disable iff (!arst_n)
		(state_r == CSO_ST_MEMWAIT) |-> !pfq_flush && !fetch_hold)
		else $error("barrier disturbed prefetch");
	a_ee_take: assert property (@(posedge clk) disable iff (!arst_n)
		(issue_fire && issue_op == CSO_OP_MTMSR && !user_mode && issue_msr_val[0]
		&& !irq_event ##1 ext_irq_pending) |=> take_ext_irq)
		else $error("pending interrupt not taken after enable");
	a_msr_no_flush: assert property (@(posedge clk) disable iff (!arst_n)
		(issue_fire && issue_op == CSO_OP_MTMSR && !user_mode && !irq_event) |=> !refetch_req)
		else $error("state write refetched prefetch");
	a_wree_nostall: assert property (@(posedge clk) disable iff (!arst_n)
		(issue_valid && issue_op == CSO_OP_WREE && state_r == CSO_ST_RUN && !ee_chk_r)
		|-> issue_ready)
		else $error("external-enable write was stalled");
	a_irq_ctx_sync: assert property (@(posedge clk) disable iff (!arst_n)
		(irq_event && !irq_nonrecov_imc) |=> ctx_switch && pfq_flush && refetch_req)
		else $error("interrupt did not synchronize context");
	a_wree_no_flush: assert property (@(posedge clk) disable iff (!arst_n)
		(ee_wr && !irq_event) |=> !pfq_flush)
		else $error("external-enable write flushed prefetch");
endmodule // cso_ctrl
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the sync and ordering control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import cso_pkg::*;
;
	logic clk, arst_n, issue_valid, pipe_empty, lsu_idle;
	logic ext_irq_pending, irq_event, irq_nonrecov_imc;
	cso_op_type issue_op;
	logic [1:0] issue_msr_val;
	logic issue_ready, issue_fire, lsu_hold, take_ext_irq, priv_exc, pfq_flush;
	logic refetch_req, fetch_hold, user_mode, ext_int_enable, ctx_switch;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;

	cso_ctrl cso_ctrl_inst (.clk(clk), .arst_n(arst_n), .issue_valid(issue_valid),
		.issue_op(issue_op), .issue_msr_val(issue_msr_val), .issue_ready(issue_ready),
		.issue_fire(issue_fire), .pipe_empty(pipe_empty), .lsu_idle(lsu_idle),
		.lsu_hold(lsu_hold), .ext_irq_pending(ext_irq_pending), .irq_event(irq_event),
		.irq_nonrecov_imc(irq_nonrecov_imc), .take_ext_irq(take_ext_irq),
		.priv_exc(priv_exc), .pfq_flush(pfq_flush), .refetch_req(refetch_req),
		.fetch_hold(fetch_hold), .user_mode(user_mode), .ext_int_enable(ext_int_enable),
		.ctx_switch(ctx_switch));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// a hang anywhere ends the run through the same report
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic seen, input logic exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %b seen %b", nm, exp, seen);
		end
	endtask

	// called at a falling edge; returns at the falling edge after the take edge
	task automatic issue(input cso_op_type op, input logic [1:0] v);
		int n;
		n = 0;
		issue_valid = 1'b1;
		issue_op = op;
		issue_msr_val = v;
		#1;
		while (issue_fire !== 1'b1 && n < 50) begin
			@(negedge clk);
			#1;
			n++;
		end
		chk("issue accepted", issue_fire, 1'b1);
		@(negedge clk);
		issue_valid = 1'b0;
		issue_op = CSO_OP_PLAIN;
		#1;
	endtask

	task automatic irq(input logic nonrecov);
		irq_event = 1'b1;
		irq_nonrecov_imc = nonrecov;
		@(negedge clk);
		irq_event = 1'b0;
		irq_nonrecov_imc = 1'b0;
		#1;
		chk("irq ctx_switch", ctx_switch, !nonrecov);
	endtask

	task automatic t_isync(input cso_op_type op);
		issue(op, 2'b00);
		chk("isync pfq_flush", pfq_flush, 1'b1);
		chk("isync refetch_req", refetch_req, 1'b1);
		chk("isync ctx_switch", ctx_switch, 1'b1);
		@(negedge clk);
		chk("flush one cycle", pfq_flush, 1'b0);
	endtask

	// barrier waits on older work and the load/store unit but never touches fetch
	task automatic t_barrier(input cso_op_type op);
		pipe_empty = 1'b0;
		issue_valid = 1'b1;
		issue_op = op;
		#1;
		chk("barrier waits older", issue_ready, 1'b0);
		@(negedge clk);
		pipe_empty = 1'b1;
		lsu_idle = 1'b0;
		repeat (3) @(negedge clk);
		#1;
		chk("barrier not ready", issue_ready, 1'b0);
		chk("barrier lsu_hold", lsu_hold, 1'b1);
		chk("barrier fetch_hold", fetch_hold, 1'b0);
		lsu_idle = 1'b1;
		issue(op, 2'b00);
		chk("barrier no flush", pfq_flush, 1'b0);
		chk("barrier no refetch", refetch_req, 1'b0);
		chk("barrier lsu released", lsu_hold, 1'b0);
	endtask

	task automatic t_msr_irq();
		ext_irq_pending = 1'b1;
		issue(CSO_OP_MTMSR, 2'b01);
		chk("mtmsr keeps prefetch", pfq_flush, 1'b0);
		chk("mtmsr ee set", ext_int_enable, 1'b1);
		@(negedge clk);
		#1;
		chk("pending irq taken", take_ext_irq, 1'b1);
		ext_irq_pending = 1'b0;
		irq(1'b0);
		chk("irq clears ee", ext_int_enable, 1'b0);
	endtask

	// enable writes need no drained pipe, so they issue with older work pending
	task automatic t_wree();
		pipe_empty = 1'b0;
		issue(CSO_OP_WREE, 2'b01);
		chk("wree sets ee", ext_int_enable, 1'b1);
		chk("wree no flush", pfq_flush, 1'b0);
		issue(CSO_OP_WREE, 2'b00);
		chk("wree clears ee", ext_int_enable, 1'b0);
		pipe_empty = 1'b1;
	endtask

	// software ordering sequences around control writes and privilege drops
	task automatic t_sw_seq();
		issue(CSO_OP_SYNC, 2'b00);
		issue(CSO_OP_MTDCR, 2'b00);
		chk("control write ok", priv_exc, 1'b0);
		issue(CSO_OP_ICINV, 2'b00);
		t_isync(CSO_OP_ISYNC);
		issue(CSO_OP_MTMSR, 2'b10);
		t_isync(CSO_OP_ISYNC);
		chk("user after sync", user_mode, 1'b1);
		irq(1'b0);
	endtask

	task automatic t_priv();
		cso_op_type ops[6];
		ops = '{CSO_OP_MTDCR, CSO_OP_MFDCR, CSO_OP_RFI, CSO_OP_RFCI, CSO_OP_MTMSR,
			CSO_OP_WREE};
		issue(CSO_OP_MTDCR, 2'b00);
		chk("supervisor mtdcr ok", priv_exc, 1'b0);
		foreach (ops[i]) begin
			irq(1'b0);
			chk("irq clears user", user_mode, 1'b0);
			issue(CSO_OP_MTMSR, 2'b10);
			chk("enter user mode", user_mode, 1'b1);
			issue(ops[i], 2'b00);
			chk("user privileged op", priv_exc, 1'b1);
		end
		// let the fault's own context switch pass first
		@(negedge clk);
		irq(1'b1);
	endtask

	initial begin
		arst_n = 1'b0;
		issue_valid = 1'b0;
		issue_op = CSO_OP_PLAIN;
		issue_msr_val = 2'b00;
		pipe_empty = 1'b1;
		lsu_idle = 1'b1;
		ext_irq_pending = 1'b0;
		irq_event = 1'b0;
		irq_nonrecov_imc = 1'b0;
		repeat (5) @(negedge clk);
		chk("reset user_mode", user_mode, CSO_USER_RESET);
		chk("reset ee", ext_int_enable, CSO_EE_RESET);
		chk("reset flush", pfq_flush, 1'b0);
		arst_n = 1'b1;
		@(negedge clk);
		t_isync(CSO_OP_ISYNC);
		t_barrier(CSO_OP_SYNC);
		t_barrier(CSO_OP_IOBAR);
		t_msr_irq();
		t_wree();
		t_sw_seq();
		t_priv();
		t_isync(CSO_OP_ISYNC);
		t_isync(CSO_OP_SYSCALL);
		t_isync(CSO_OP_RFI);
		t_isync(CSO_OP_RFCI);
		test_done();
	end
endmodule // tb_top
`default_nettype wire
